/* verilog/cdj_pkg.sv */
// Constants, field layout and encodings of the execution block.
// Assumes a 32-bit machine with a Wishbone register window.
package cdj_pkg;
  localparam int XLEN = 32;
  localparam int RIW = 5;
  // Register window byte offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_IMM = 8'h04;
  localparam logic [7:0] A_PC = 8'h08;
  localparam logic [7:0] A_PSW = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_SEL = 8'h14;
  localparam logic [7:0] A_DATA = 8'h18;
  // Command word fields (low bit of each)
  localparam int F_OP = 0;
  localparam int F_R1 = 5;
  localparam int F_R2 = 10;
  localparam int F_R3 = 15;
  localparam int F_I5 = 20;
  localparam int SEL_SYS = 5;
  // Status word flag positions
  localparam int P_Z = 0;
  localparam int P_S = 1;
  localparam int P_OV = 2;
  localparam int P_CY = 3;
  localparam int P_SAT = 4;
  localparam int P_ID = 5;
  localparam logic [XLEN-1:0] PSW_RST = 32'h0000_0020;
  // Status register bits
  localparam int S_BUSY = 0;
  localparam int S_HALT = 1;
  localparam int S_IEN = 2;
  // Fixed register roles and steps
  localparam logic [RIW-1:0] SR_PSW = 5'h05;
  localparam logic [RIW-1:0] SP_IDX = 5'h03;
  localparam int POP_BASE = 20;
  localparam logic [XLEN-1:0] WSTEP = 32'h0000_0004;
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_H = 2'h1;
  localparam logic [1:0] SZ_W = 2'h2;

  typedef enum logic [4:0] {
    OP_NOP = 5'b00000, OP_DISPOSE = 5'b00001, OP_DIV = 5'b00010,
    OP_DIVH2 = 5'b00011, OP_DIVH3 = 5'b00100, OP_UNSIGNED_HALF_DIVIDE = 5'b00101,
    OP_UNSIGNED_WORD_DIVIDE = 5'b00110, OP_EI = 5'b00111, OP_DI = 5'b01000,
    OP_HALT = 5'b01001, OP_HSW = 5'b01010, OP_JUMP_WITH_LINK = 5'b01011,
    OP_JMP = 5'b01100, OP_JR = 5'b01101, OP_LDB = 5'b01110,
    OP_LDBU = 5'b01111, OP_LDH = 5'b10000, OP_LDHU = 5'b10001,
    OP_LDW = 5'b10010, OP_SYSTEM_REGISTER_WRITE = 5'b10011, OP_MOVR = 5'b10100,
    OP_MOVI5 = 5'b10101, OP_MOVI32 = 5'b10110, OP_EFFECTIVE_ADDRESS_ADD = 5'b10111
  } cdj_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_EXEC = 3'b001, ST_DIVW = 3'b010,
    ST_MEMW = 3'b011, ST_POP = 3'b100, ST_HALT = 3'b101
  } cdj_state_t;

  function automatic logic [XLEN-1:0] sx16(input logic [XLEN-1:0] v);
    return {{16{v[15]}}, v[15:0]};
  endfunction : sx16

  function automatic logic [XLEN-1:0] sx22(input logic [XLEN-1:0] v);
    return {{10{v[21]}}, v[21:1], 1'b0};
  endfunction : sx22

  function automatic logic [XLEN-1:0] sx5(input logic [RIW-1:0] v);
    return {{27{v[4]}}, v};
  endfunction : sx5
endpackage : cdj_pkg

/* verilog/cdj_div_if.sv */
// Request and answer bundle between the executor and its divider.
// Assumes both ends share clk_sys.
`timescale 1ns/1ns
interface cdj_div_if #(parameter int W = 32);
  logic start;
  logic sgn;
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic done;
  logic busy;
  logic [W-1:0] q;
  logic [W-1:0] r;
  logic ovf;
  modport req (output start, sgn, a, b, input done, busy, q, r, ovf);
  modport rsp (input start, sgn, a, b, output done, busy, q, r, ovf);
endinterface : cdj_div_if

/* verilog/cdj_div.sv */
// Sequential restoring divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse given only while not busy.
`timescale 1ns/1ns
module cdj_div #(parameter int W = 32) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Request and answer
  cdj_div_if.rsp d
);
  localparam int CW = $clog2(W + 1);
  if (W < 2) begin : g_bad
    $error("cdj_div needs W of at least 2");
  end
  logic busy_q, done_q, ovf_q, qneg_q, rneg_q;
  logic [CW-1:0] cnt_q;
  logic [W:0] rem_q;
  logic [W-1:0] quo_q, bm_q, q_q, r_q;
  logic [W-1:0] am, bmag;
  logic [W:0] rsh, tr;
  assign am = (d.sgn && d.a[W-1]) ? W'(-d.a) : d.a;
  assign bmag = (d.sgn && d.b[W-1]) ? W'(-d.b) : d.b;
  assign rsh = {rem_q[W-1:0], quo_q[W-1]};
  assign tr = rsh - {1'b0, bm_q};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ovf_q <= 1'b0;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
      cnt_q <= '0;
      rem_q <= '0;
      quo_q <= '0;
      bm_q <= '0;
      q_q <= '0;
      r_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (d.start && !busy_q) begin
        if (d.b == '0) begin
          // Zero divisor: no trap, fixed answer
          done_q <= 1'b1;
          ovf_q <= 1'b1;
          q_q <= '0;
          r_q <= d.a;
        end else if (d.sgn && d.a == {1'b1, {(W-1){1'b0}}} && d.b == '1) begin
          done_q <= 1'b1;
          ovf_q <= 1'b1;
          q_q <= d.a;
          r_q <= '0;
        end else begin
          busy_q <= 1'b1;
          ovf_q <= 1'b0;
          cnt_q <= CW'(W);
          rem_q <= '0;
          quo_q <= am;
          bm_q <= bmag;
          qneg_q <= d.sgn && (d.a[W-1] ^ d.b[W-1]);
          rneg_q <= d.sgn && d.a[W-1];
        end
      end else if (busy_q && cnt_q != '0) begin
        cnt_q <= cnt_q - CW'(1);
        rem_q <= tr[W] ? rsh : tr;
        quo_q <= {quo_q[W-2:0], !tr[W]};
      end else if (busy_q) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        q_q <= qneg_q ? W'(-quo_q) : quo_q;
        r_q <= rneg_q ? W'(-rem_q[W-1:0]) : rem_q[W-1:0];
      end
    end
  end

  assign d.busy = busy_q;
  assign d.done = done_q;
  assign d.q = q_q;
  assign d.r = r_q;
  assign d.ovf = ovf_q;
endmodule : cdj_div

/* verilog/cdj_exec.sv */
// Executor for divide, jump, load, move and system-control instructions.
// Assumes a Wishbone classic master, a data memory answering mem_req with
// a one-cycle mem_ack and an aligned little-endian word on mem_rdata.
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ns
module cdj_exec import cdj_pkg::*; #(
  parameter int LIST_BITS = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Wishbone register window
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [XLEN-1:0] wb_dat_i,
  output logic [XLEN-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Data memory read port
  output logic mem_req,
  output logic [XLEN-1:0] mem_addr,
  output logic [1:0] mem_size,
  input wire logic mem_ack,
  input wire logic [XLEN-1:0] mem_rdata,
  // Interrupt and standby
  input wire logic irq_req,
  output logic irq_accept,
  output logic clk_stop
);
  localparam int IW = $clog2(LIST_BITS + 1);
  if (LIST_BITS < 1 || POP_BASE + LIST_BITS > XLEN) begin : g_bad
    $error("cdj_exec LIST_BITS out of range");
  end

  cdj_state_t state_q, state_d;
  logic [XLEN-1:0] gpr_q [XLEN];
  logic [XLEN-1:0] sreg_q [XLEN];
  logic [XLEN-1:0] pc_q, pc_d, psw_q, psw_d, imm_q, cmd_q, ea_q, ea_d;
  logic [XLEN-1:0] tgt_q, tgt_d, wb_dat_q, rd_mux;
  logic [IW-1:0] idx_q, idx_d;
  logic [5:0] sel_q;
  logic wb_ack_q, wb_req, wb_wr, cmd_go;
  logic gw0_en, gw1_en, sw_en;
  logic [RIW-1:0] gw0_idx, gw1_idx;
  logic [XLEN-1:0] gw0_dat, gw1_dat, sw_dat;
  cdj_op_t op;
  logic [RIW-1:0] r1, r2, r3, i5;
  logic [XLEN-1:0] v1, v2, sp, ld_sh, ld_v, hsw_r;
  logic [LIST_BITS-1:0] list;

  cdj_div_if #(.W(XLEN)) dv ();
  cdj_div #(.W(XLEN)) u_div (.clk_sys(clk_sys), .rst_n(rst_n), .d(dv));

  function automatic logic [XLEN-1:0] merge(input logic [XLEN-1:0] o,
      input logic [XLEN-1:0] n, input logic [3:0] s);
    logic [XLEN-1:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) m[i*8 +: 8] = n[i*8 +: 8];
    end
    return m;
  endfunction : merge

  assign op = cdj_op_t'(cmd_q[F_OP +: RIW]);
  assign r1 = cmd_q[F_R1 +: RIW];
  assign r2 = cmd_q[F_R2 +: RIW];
  assign r3 = cmd_q[F_R3 +: RIW];
  assign i5 = cmd_q[F_I5 +: RIW];
  assign v1 = gpr_q[r1];
  assign v2 = gpr_q[r2];
  assign sp = gpr_q[SP_IDX];
  assign list = imm_q[LIST_BITS-1:0];
  assign hsw_r = {v2[15:0], v2[31:16]};
  // Memory returns the whole aligned word; halfwords ignore address bit 0
  assign ld_sh = mem_rdata >> {ea_q[1], ea_q[0] && (op == OP_LDB || op == OP_LDBU), 3'b000};

  // Bus slave: one wait state, unmapped reads give zero
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
  assign wb_wr = wb_req && wb_we_i;
  assign cmd_go = wb_wr && wb_adr_i == A_CMD && state_q == ST_IDLE;

  always_comb begin
    unique case (wb_adr_i)
      A_CMD: rd_mux = cmd_q;
      A_IMM: rd_mux = imm_q;
      A_PC: rd_mux = pc_q;
      A_PSW: rd_mux = psw_q;
      A_STAT: rd_mux = XLEN'({psw_q[P_ID] == 1'b0, state_q == ST_HALT,
                              state_q != ST_IDLE && state_q != ST_HALT});
      A_SEL: rd_mux = XLEN'(sel_q);
      A_DATA: rd_mux = sel_q[SEL_SYS] ? (sel_q[RIW-1:0] == SR_PSW ? psw_q :
                       sreg_q[sel_q[RIW-1:0]]) : gpr_q[sel_q[RIW-1:0]];
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= '0;
    end else begin
      wb_ack_q <= wb_req;
      if (wb_req) wb_dat_q <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= '0;
      imm_q <= '0;
      sel_q <= '0;
    end else begin
      if (cmd_go) cmd_q <= wb_dat_i;
      if (wb_wr && wb_adr_i == A_IMM && state_q == ST_IDLE) begin
        imm_q <= merge(imm_q, wb_dat_i, wb_sel_i);
      end
      if (wb_wr && wb_adr_i == A_SEL) sel_q <= wb_dat_i[5:0];
    end
  end

  // Divider request, operands chosen per divide flavour
  always_comb begin
    dv.start = state_q == ST_EXEC && (op == OP_DIV || op == OP_DIVH2 ||
               op == OP_DIVH3 || op == OP_UNSIGNED_HALF_DIVIDE || op == OP_UNSIGNED_WORD_DIVIDE);
    dv.sgn = op == OP_DIV || op == OP_DIVH2 || op == OP_DIVH3;
    dv.a = v2;
    unique case (op)
      OP_DIVH2, OP_DIVH3: dv.b = {{16{v1[15]}}, v1[15:0]};
      OP_UNSIGNED_HALF_DIVIDE: dv.b = {16'h0000, v1[15:0]};
      default: dv.b = v1;
    endcase
  end

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    psw_d = psw_q;
    ea_d = ea_q;
    tgt_d = tgt_q;
    idx_d = idx_q;
    gw0_en = 1'b0;
    gw0_idx = r2;
    gw0_dat = '0;
    gw1_en = 1'b0;
    gw1_idx = r3;
    gw1_dat = '0;
    sw_en = 1'b0;
    sw_dat = v2;
    mem_req = 1'b0;
    mem_addr = {ea_q[XLEN-1:2], 2'b00};
    mem_size = SZ_W;
    ld_v = mem_rdata;
    unique case (state_q)
      ST_IDLE: begin
        gw0_en = wb_wr && wb_adr_i == A_DATA && !sel_q[SEL_SYS];
        gw0_idx = sel_q[RIW-1:0];
        gw0_dat = merge(gpr_q[sel_q[RIW-1:0]], wb_dat_i, wb_sel_i);
        if (cmd_go) begin
          state_d = ST_EXEC;
          if (cdj_op_t'(wb_dat_i[F_OP +: RIW]) == OP_DI) begin
            psw_d[P_ID] = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        state_d = ST_IDLE;
        pc_d = pc_q + WSTEP;
        ea_d = v1 + sx16(imm_q);
        unique case (op)
          OP_DISPOSE: begin
            gw0_en = 1'b1;
            gw0_idx = SP_IDX;
            gw0_dat = sp + {25'h0, i5, 2'b00};
            tgt_d = v1;
            idx_d = '0;
            state_d = ST_POP;
            pc_d = pc_q;
          end
          OP_DIV, OP_DIVH2, OP_DIVH3, OP_UNSIGNED_HALF_DIVIDE, OP_UNSIGNED_WORD_DIVIDE: begin
            state_d = ST_DIVW;
            pc_d = pc_q;
          end
          OP_EI: psw_d[P_ID] = 1'b0;
          OP_DI: psw_d[P_ID] = 1'b1;
          OP_HALT: state_d = ST_HALT;
          OP_HSW: begin
            gw0_en = 1'b1;
            gw0_idx = r3;
            gw0_dat = hsw_r;
            psw_d[P_CY] = hsw_r[15:0] == 16'h0000 || hsw_r[31:16] == 16'h0000;
            psw_d[P_OV] = 1'b0;
            psw_d[P_S] = hsw_r[XLEN-1];
            psw_d[P_Z] = hsw_r == '0;
          end
          OP_JUMP_WITH_LINK: begin
            gw0_en = 1'b1;
            gw0_dat = pc_q + WSTEP;
            pc_d = pc_q + sx22(imm_q);
          end
          OP_JMP: pc_d = {v1[XLEN-1:1], 1'b0};
          OP_JR: pc_d = pc_q + sx22(imm_q);
          OP_LDB, OP_LDBU, OP_LDH, OP_LDHU, OP_LDW: begin
            state_d = ST_MEMW;
            pc_d = pc_q;
          end
          OP_SYSTEM_REGISTER_WRITE: begin
            if (i5 == SR_PSW) psw_d = v2;
            else sw_en = 1'b1;
          end
          OP_MOVR: begin
            gw0_en = 1'b1;
            gw0_dat = v1;
          end
          OP_MOVI5: begin
            gw0_en = 1'b1;
            gw0_dat = sx5(i5);
          end
          OP_MOVI32: begin
            gw0_en = 1'b1;
            gw0_idx = r1;
            gw0_dat = imm_q;
          end
          OP_EFFECTIVE_ADDRESS_ADD: begin
            gw0_en = 1'b1;
            gw0_dat = v1 + sx16(imm_q);
          end
          default: ;
        endcase
      end
      ST_DIVW: begin
        if (dv.done) begin
          state_d = ST_IDLE;
          pc_d = pc_q + WSTEP;
          gw0_en = 1'b1;
          gw0_dat = dv.q;
          gw1_en = op != OP_DIVH2;
          gw1_dat = dv.r;
          psw_d[P_OV] = dv.ovf;
          psw_d[P_S] = dv.q[XLEN-1];
          psw_d[P_Z] = dv.q == '0;
        end
      end
      ST_MEMW: begin
        mem_req = 1'b1;
        unique case (op)
          OP_LDB, OP_LDBU: begin
            mem_size = SZ_B;
            ld_v = op == OP_LDB ? {{24{ld_sh[7]}}, ld_sh[7:0]}
                                : {24'h000000, ld_sh[7:0]};
          end
          OP_LDH, OP_LDHU: begin
            mem_addr = {ea_q[XLEN-1:1], 1'b0};
            mem_size = SZ_H;
            ld_v = op == OP_LDH ? {{16{ld_sh[15]}}, ld_sh[15:0]}
                                : {16'h0000, ld_sh[15:0]};
          end
          default: ld_v = mem_rdata;
        endcase
        if (op == OP_LDB || op == OP_LDBU) mem_addr = ea_q;
        if (mem_ack) begin
          state_d = ST_IDLE;
          pc_d = pc_q + WSTEP;
          gw0_en = 1'b1;
          gw0_dat = ld_v;
        end
      end
      ST_POP: begin
        mem_addr = {sp[XLEN-1:2], 2'b00};
        if (idx_q == IW'(LIST_BITS)) begin
          state_d = ST_IDLE;
          pc_d = tgt_q;
        end else if (list[idx_q]) begin
          mem_req = 1'b1;
          if (mem_ack) begin
            gw0_en = 1'b1;
            gw0_idx = RIW'(POP_BASE + int'(idx_q));
            gw0_dat = mem_rdata;
            gw1_en = 1'b1;
            gw1_idx = SP_IDX;
            gw1_dat = sp + WSTEP;
            idx_d = idx_q + IW'(1);
          end
        end else begin
          idx_d = idx_q + IW'(1);
        end
      end
      ST_HALT: if (irq_req) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      pc_q <= '0;
      psw_q <= PSW_RST;
      ea_q <= '0;
      tgt_q <= '0;
      idx_q <= '0;
    end else begin
      state_q <= state_d;
      pc_q <= (wb_wr && wb_adr_i == A_PC && state_q == ST_IDLE) ?
              merge(pc_q, wb_dat_i, wb_sel_i) : pc_d;
      psw_q <= psw_d;
      ea_q <= ea_d;
      tgt_q <= tgt_d;
      idx_q <= idx_d;
    end
  end

  // Quotient port written last so it wins when both name one register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < XLEN; i++) gpr_q[i] <= '0;
    end else begin
      if (gw1_en && gw1_idx != '0) gpr_q[gw1_idx] <= gw1_dat;
      if (gw0_en && gw0_idx != '0) gpr_q[gw0_idx] <= gw0_dat;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < XLEN; i++) sreg_q[i] <= '0;
    end else if (sw_en) begin
      sreg_q[i5] <= sw_dat;
    end
  end

  // Disable flag gates acceptance; a DI command blocks in its own cycle
  assign irq_accept = irq_req && state_q == ST_IDLE && !psw_q[P_ID] &&
                      !(cmd_go && cdj_op_t'(wb_dat_i[F_OP +: RIW]) == OP_DI);
  assign clk_stop = state_q == ST_HALT;
  assign wb_dat_o = wb_dat_q;
  assign wb_ack_o = wb_ack_q;
endmodule : cdj_exec

/* sim/cdj_exec_monitor.sv */
// Concurrent checks on the executor's bus, memory and standby ports.
// Assumes it is bound to cdj_exec and sees only its ports.
`timescale 1ns/1ns
module cdj_exec_monitor import cdj_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Memory port
  input wire logic mem_req,
  input wire logic [XLEN-1:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic mem_ack,
  // Interrupt and standby
  input wire logic irq_req,
  input wire logic irq_accept,
  input wire logic clk_stop
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_mem_wait;
    mem_req && !mem_ack;
  endsequence
  ack_next_a: assert property (s_bus_req |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  mem_hold_a: assert property (
    s_mem_wait |=> mem_req && $stable(mem_addr) && $stable(mem_size))
    else $error("memory request changed before answer");
  word_align_a: assert property (
    mem_req && mem_size == SZ_W |-> mem_addr[1:0] == 2'h0)
    else $error("word read not word aligned");
  half_align_a: assert property (
    mem_req && mem_size == SZ_H |-> mem_addr[0] == 1'b0)
    else $error("halfword read not aligned");
  irq_idle_a: assert property (
    irq_accept |-> irq_req && !mem_req && !clk_stop)
    else $error("interrupt accepted while not idle");
  stop_quiet_a: assert property (clk_stop |-> !mem_req)
    else $error("memory access during standby");
  stop_wake_a: assert property (clk_stop && irq_req |-> ##[1:2] !clk_stop)
    else $error("standby not left on interrupt");
endmodule : cdj_exec_monitor

bind cdj_exec cdj_exec_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_req(mem_req),
  .mem_addr(mem_addr), .mem_size(mem_size), .mem_ack(mem_ack), .irq_req(irq_req),
  .irq_accept(irq_accept), .clk_stop(clk_stop));

/* sim/cdj_mem_model.sv */
// Data memory model answering word reads after lat idle cycles.
// Assumes the requester holds mem_req and its address until mem_ack.
`timescale 1ns/1ns
module cdj_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Read port
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [3:0] cnt_q;
  function automatic logic [31:0] word_at(input logic [31:0] a);
    return {a[9:2] ^ 8'h5A, a[9:2] ^ 8'hC3, a[9:2] ^ 8'h96, a[9:2] ^ 8'h2E};
  endfunction : word_at
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      // Toggle outside answers so stale data never looks valid
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (cnt_q >= lat) begin
          mem_ack <= 1'b1;
          mem_rdata <= word_at(mem_addr);
          cnt_q <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule : cdj_mem_model

/* sim/cdj_exec_bench.sv */
// Self-checking bench for the executor over its register window.
// Assumes cdj_exec, its monitor and the memory model are compiled first.
`timescale 1ns/1ns
module cdj_exec_bench;
  import cdj_pkg::*;
  logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, irq_req;
  logic wb_ack_o, mem_req, mem_ack, irq_accept, clk_stop;
  logic [7:0] wb_adr_i;
  logic [3:0] lat;
  logic [1:0] mem_size;
  logic [31:0] wb_dat_i, wb_dat_o, mem_addr, mem_rdata;
  int fail_count, checks, cycles;
  cdj_exec dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_size(mem_size), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .irq_req(irq_req), .irq_accept(irq_accept), .clk_stop(clk_stop));
  cdj_mem_model u_mem (.clk_sys(clk_sys), .rst_n(rst_n), .mem_req(mem_req),
    .mem_addr(mem_addr), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(n, q, e);
  endtask : rdc
  task automatic setr(input logic [4:0] i, input logic [31:0] v);
    wr(A_SEL, {27'h0, i});
    wr(A_DATA, v);
  endtask : setr
  task automatic getr(input logic [4:0] i, input logic [31:0] e);
    wr(A_SEL, {27'h0, i});
    rdc($sformatf("r%0d", i), A_DATA, e);
  endtask : getr
  task automatic exec(input cdj_op_t op, input logic [4:0] r1, r2, r3, i5);
    logic [31:0] s;
    wr(A_CMD, {7'h00, i5, r3, r2, r1, op});
    do wb(1'b0, A_STAT, 32'h0, s); while (s[S_BUSY] !== 1'b0 && s[S_HALT] !== 1'b1);
  endtask : exec
  task automatic t_reset;
    rdc("psw", A_PSW, PSW_RST);
    rdc("unmapped", 8'h40, 32'h0);
    irq_req <= 1'b1;
    @(posedge clk_sys);
    #1 check("irq_accept", {31'h0, irq_accept}, 32'h0);
    @(posedge clk_sys);
    irq_req <= 1'b0;
    $display("reset test done");
  endtask : t_reset
  task automatic t_move;
    exec(OP_MOVI5, 0, 2, 0, 5'h1B);
    getr(2, 32'hFFFF_FFFB);
    exec(OP_MOVR, 2, 4, 0, 0);
    getr(4, 32'hFFFF_FFFB);
    wr(A_IMM, 32'h89AB_CDEF);
    exec(OP_MOVI32, 6, 0, 0, 0);
    getr(6, 32'h89AB_CDEF);
    wr(A_IMM, 32'h0000_8000);
    exec(OP_EFFECTIVE_ADDRESS_ADD, 6, 7, 0, 0);
    getr(7, 32'h89AB_4DEF);
    rdc("psw", A_PSW, 32'h0000_0020);
    $display("move test done");
  endtask : t_move
  task automatic t_div;
    cdj_op_t op [6] = '{OP_DIV, OP_DIVH2, OP_DIVH3, OP_UNSIGNED_HALF_DIVIDE, OP_UNSIGNED_WORD_DIVIDE, OP_DIV};
    logic [31:0] a [6] = '{32'hFFFF_FFF9, 32'h0001_0000, 32'h64, 32'hFFFF_FFFF,
                           32'h8000_0000, 32'h5};
    logic [31:0] b [6] = '{32'h2, 32'h1234_FFFE, 32'hFFFF_0007, 32'hABCD_0010,
                           32'h8000_0000, 32'h0};
    logic [31:0] q [6] = '{32'hFFFF_FFFD, 32'hFFFF_8000, 32'hE, 32'h0FFF_FFFF, 32'h1, 32'h0};
    logic [31:0] r [6] = '{32'hFFFF_FFFF, 32'h0BAD_0BAD, 32'h2, 32'hF, 32'h0, 32'h5};
    logic [31:0] p [6] = '{32'h3A, 32'h3A, 32'h38, 32'h38, 32'h38, 32'h3C};
    logic [31:0] m [6] = '{32'h3F, 32'h3F, 32'h3F, 32'h3F, 32'h3F, 32'h3C};
    logic [31:0] s;
    setr(1, 32'h38);
    exec(OP_SYSTEM_REGISTER_WRITE, 0, 1, 0, SR_PSW);
    rdc("psw", A_PSW, 32'h38);
    for (int i = 0; i < 6; i++) begin
      setr(8, b[i]);
      setr(9, a[i]);
      setr(10, 32'h0BAD_0BAD);
      exec(op[i], 8, 9, 10, 0);
      getr(9, q[i]);
      getr(10, r[i]);
      wb(1'b0, A_PSW, 32'h0, s);
      check("div flags", s & m[i], p[i]);
    end
    $display("divide test done");
  endtask : t_div
  task automatic t_jump;
    setr(1, 32'h24);
    exec(OP_SYSTEM_REGISTER_WRITE, 0, 1, 0, SR_PSW);
    setr(11, 32'h0000_1234);
    exec(OP_HSW, 0, 11, 12, 0);
    getr(12, 32'h1234_0000);
    rdc("psw", A_PSW, 32'h28);
    wr(A_PC, 32'h1000);
    wr(A_IMM, 32'h0020_0005);
    exec(OP_JR, 0, 0, 0, 0);
    rdc("pc", A_PC, 32'hFFE0_1004);
    wr(A_PC, 32'h2000);
    wr(A_IMM, 32'h101);
    exec(OP_JUMP_WITH_LINK, 0, 12, 0, 0);
    rdc("pc", A_PC, 32'h2100);
    getr(12, 32'h2004);
    setr(13, 32'h3001);
    exec(OP_JMP, 13, 0, 0, 0);
    rdc("pc", A_PC, 32'h3000);
    rdc("psw", A_PSW, 32'h28);
    $display("jump test done");
  endtask : t_jump
  task automatic t_load;
    cdj_op_t op [5] = '{OP_LDB, OP_LDBU, OP_LDH, OP_LDHU, OP_LDW};
    logic [15:0] dsp [2] = '{16'h0005, 16'hFFFB};
    logic [31:0] ea, w, b, h, e;
    setr(14, 32'h100);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 5; i++) begin
        lat <= 4'(2 * (i % 3));
        wr(A_IMM, {16'h0, dsp[j]});
        exec(op[i], 14, 15, 0, 0);
        ea = 32'h100 + {{16{dsp[j][15]}}, dsp[j]};
        w = u_mem.word_at(ea);
        b = w >> {ea[1:0], 3'b000};
        h = w >> {ea[1], 4'h0};
        case (i)
          0: e = {{24{b[7]}}, b[7:0]};
          1: e = {24'h0, b[7:0]};
          2: e = {{16{h[15]}}, h[15:0]};
          3: e = {16'h0, h[15:0]};
          default: e = w;
        endcase
        getr(15, e);
      end
    end
    $display("load test done");
  endtask : t_load
  task automatic t_dispose;
    setr(3, 32'h200);
    setr(16, 32'h4444);
    setr(21, 32'h0BAD_0BAD);
    wr(A_IMM, 32'h005);
    exec(OP_DISPOSE, 16, 0, 0, 2);
    getr(20, u_mem.word_at(32'h208));
    getr(21, 32'h0BAD_0BAD);
    getr(22, u_mem.word_at(32'h20C));
    getr(3, 32'h210);
    rdc("pc", A_PC, 32'h4444);
    $display("dispose test done");
  endtask : t_dispose
  task automatic t_irq;
    irq_req <= 1'b1;
    exec(OP_EI, 0, 0, 0, 0);
    @(posedge clk_sys);
    #1 check("irq_accept", {31'h0, irq_accept}, 32'h1);
    rdc("psw", A_PSW, 32'h08);
    exec(OP_DI, 0, 0, 0, 0);
    @(posedge clk_sys);
    #1 check("irq_accept", {31'h0, irq_accept}, 32'h0);
    @(posedge clk_sys);
    irq_req <= 1'b0;
    exec(OP_HALT, 0, 0, 0, 0);
    @(posedge clk_sys);
    #1 check("clk_stop", {31'h0, clk_stop}, 32'h1);
    @(posedge clk_sys);
    irq_req <= 1'b1;
    for (int k = 0; k < 8 && clk_stop !== 1'b0; k++) @(posedge clk_sys);
    check("clk_stop", {31'h0, clk_stop}, 32'h0);
    irq_req <= 1'b0;
    rdc("psw", A_PSW, 32'h28);
    $display("interrupt test done");
  endtask : t_irq
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Ceiling well above the several hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize;
    end
  end
  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    irq_req = 1'b0;
    lat = 4'h1;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_move;
    t_div;
    t_jump;
    t_load;
    t_dispose;
    t_irq;
    summarize;
  end
endmodule : cdj_exec_bench
